// File: pkg/header_compare_pkg.sv
package header_compare_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int PADDR_BITS = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SYNC_PATTERN = 8'h0c;

  // control fields
  localparam int CTL_DRIVE_TYPE = 0;
  localparam int CTL_WRITE_CHECK = 1;
  localparam int CTL_CLEAR_ENABLE = 2;
  localparam int CTL_SKIP_INHIBIT_N = 3;
  localparam int CTL_COND_LSB = 4;
  localparam int CTL_COND_MSB = 5;

  // status fields
  localparam int STS_COMPARE = 0;
  localparam int STS_MISMATCH_N = 1;
  localparam int STS_SKIP = 2;
  localparam int STS_SYNC = 3;
  localparam int STS_COUNT_LSB = 8;
  localparam int STS_COUNT_MSB = 13;

  // ---------------------------------------------------------------
  // header geometry
  // ---------------------------------------------------------------
  localparam int ADDR_BITS = 20;
  localparam int COUNT_BITS = 6;
  localparam int INDEX_BITS = 5;
  localparam logic [COUNT_BITS-1:0] HDR16_LEN = 6'h10;
  localparam logic [COUNT_BITS-1:0] HDR20_LEN = 6'h20;
  localparam logic [COUNT_BITS-1:0] FIRST_COUNT = 6'h01;
  localparam logic [COUNT_BITS-1:0] SKIP_COUNT = 6'h0e;
  localparam logic [COUNT_BITS-1:0] SEG_HIGH_BASE = 6'h09;
  localparam logic [COUNT_BITS-1:0] SEG_HIGH_END = 6'h0a;
  localparam logic [COUNT_BITS-1:0] SEG_LOW_START = 6'h10;
  localparam logic [COUNT_BITS-1:0] SEG_LOW_END = 6'h18;
  localparam logic [7:0] SYNC_PATTERN_16 = 8'h80;
  localparam logic [7:0] SYNC_PATTERN_20 = 8'h19;
  localparam logic [1:0] COND_TEST_COMPARE = 2'b10;

  // ---------------------------------------------------------------
  // carriers and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic link_clk;
    logic read_data;
    logic sync_found;
  } link_type;

  typedef struct packed {
    logic [INDEX_BITS-1:0] index;
    logic force_high;
  } slot_type;

  typedef struct packed {
    logic [COUNT_BITS-1:0] count;
    logic serial_bit;
    logic serial_force;
    logic compare;
    logic mismatch_n;
    logic skip;
    logic [7:0] sync_pattern;
    logic clk_prev;
    logic sync_prev;
    logic drive_type;
    logic write_check;
    logic clear_enable;
    logic skip_inhibit_n;
    logic [1:0] cond;
    logic [ADDR_BITS-1:0] address;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    count: 6'h00, serial_bit: 1'b0, serial_force: 1'b0, compare: 1'b1,
    mismatch_n: 1'b1, skip: 1'b0, sync_pattern: SYNC_PATTERN_16,
    clk_prev: 1'b0, sync_prev: 1'b0, drive_type: 1'b0, write_check: 1'b0,
    clear_enable: 1'b0, skip_inhibit_n: 1'b1, cond: 2'b00,
    address: 20'h00000, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};

  // ---------------------------------------------------------------
  // bit order tables
  // ---------------------------------------------------------------
  function automatic slot_type slot_16(input logic [COUNT_BITS-1:0] count);
    slot_type s;
    s.index = count[INDEX_BITS-1:0];
    s.force_high = 1'b0;
    return s;
  endfunction

  // long header: address 9..19, flags, address 0..8, flags
  function automatic slot_type slot_20(input logic [COUNT_BITS-1:0] count);
    slot_type s;
    s.index = '0;
    s.force_high = 1'b1;
    if (count <= SEG_HIGH_END) begin
      s.index = INDEX_BITS'(count + SEG_HIGH_BASE);
      s.force_high = 1'b0;
    end else if (count >= SEG_LOW_START && count <= SEG_LOW_END) begin
      s.index = INDEX_BITS'(count - SEG_LOW_START);
      s.force_high = 1'b0;
    end
    return s;
  endfunction

endpackage

// File: hdl/bit_synchronizer.sv
module bit_synchronizer #(
  parameter int WIDTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ---------------------------------------------------------------
  // two flop chain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } chain_type;

  chain_type chain_r;
  chain_type chain_nxt;

  always_comb begin
    chain_nxt.first = async_in;
    chain_nxt.second = chain_r.first;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_r <= '0;
    end else begin
      chain_r <= chain_nxt;
    end
  end

  assign sync_out = chain_r.second;

endmodule

// File: hdl/header_comparator.sv
// Behaviour
// - short header: address bit 0 first, 15 last
// - drive type select low short, high long
// - clear enable before sync holds count zero
// - count zero presents first bit, 0 or 9
// - compare held set until sync found
// - sync found presets count to one
// - first link edge samples compare, advances count
// - count runs one ahead of compared bit
// - xor sets compare, feedback keeps it set
// - test select 10 gates compare to result
// - result low active: high match, low mismatch
// - no write check: compare read data
// - short header: read data passes unmasked
// - long header: flag counts force data high
// - long header: flag counts force address high
// - long header: address 19..0 reordered, 9 first
// - long header: skip detector latches data at count 14
// - skip flag is header bit 13
// - sync pattern 80 short, 19 long
module header_comparator #(
  parameter int HDR16_BITS = 16,
  parameter int HDR20_BITS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [header_compare_pkg::PADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire header_compare_pkg::link_type link_in,
  output logic serial_address_bit,
  output logic mismatch_n,
  output logic skip_sector_detect,
  output logic drive_type_select,
  output logic [7:0] sync_pattern_constant
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  generate
    if (HDR16_BITS < 1 || HDR16_BITS > 16 || HDR20_BITS < 25 || HDR20_BITS > 62) begin : g_bad
      $error("header length out of range");
    end
  endgenerate

  localparam logic [header_compare_pkg::COUNT_BITS-1:0] LEN16 =
    header_compare_pkg::COUNT_BITS'(HDR16_BITS);
  localparam logic [header_compare_pkg::COUNT_BITS-1:0] LEN20 =
    header_compare_pkg::COUNT_BITS'(HDR20_BITS);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  header_compare_pkg::link_type link_s;

  bit_synchronizer #(
    .WIDTH($bits(header_compare_pkg::link_type))
  ) i_bit_synchronizer (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(link_in),
    .sync_out(link_s)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  header_compare_pkg::state_type s_r;
  header_compare_pkg::state_type s_nxt;
  header_compare_pkg::slot_type slot;
  logic link_rise;
  logic sync_rise;
  logic mux_bit;
  logic masked_data;
  logic step;
  logic access;
  logic mapped;
  logic [header_compare_pkg::COUNT_BITS-1:0] hdr_len;
  logic [31:0] read_word;

  always_comb begin
    s_nxt = s_r;
    link_rise = link_s.link_clk & ~s_r.clk_prev;
    sync_rise = link_s.sync_found & ~s_r.sync_prev;
    s_nxt.clk_prev = link_s.link_clk;
    s_nxt.sync_prev = link_s.sync_found;
    hdr_len = s_r.drive_type ? LEN20 : LEN16;

    // bit select and bit assertion gates
    if (s_r.drive_type) begin
      slot = header_compare_pkg::slot_20(s_r.count);
    end else begin
      slot = header_compare_pkg::slot_16(s_r.count);
    end
    mux_bit = slot.force_high | s_r.address[slot.index];

    // read data modifier
    masked_data = link_s.read_data;
    if (s_r.drive_type && !s_r.write_check && s_r.serial_force) begin
      masked_data = 1'b1;
    end

    step = 1'b0;
    if (!link_s.sync_found) begin
      s_nxt.compare = 1'b1;
      if (s_r.clear_enable) begin
        s_nxt.count = '0;
        s_nxt.skip = 1'b0;
      end
      if (s_r.count == '0) begin
        s_nxt.serial_bit = mux_bit;
        s_nxt.serial_force = slot.force_high;
      end
    end else if (sync_rise) begin
      s_nxt.count = header_compare_pkg::FIRST_COUNT;
      s_nxt.compare = 1'b0;
    end else if (link_rise && !s_r.write_check && s_r.count <= hdr_len) begin
      step = 1'b1;
      s_nxt.compare = s_r.compare | (s_r.serial_bit ^ masked_data);
      s_nxt.count = s_r.count + header_compare_pkg::FIRST_COUNT;
      s_nxt.serial_bit = mux_bit;
      s_nxt.serial_force = slot.force_high;
      if (s_r.drive_type && s_r.skip_inhibit_n && s_r.count == header_compare_pkg::SKIP_COUNT) begin
        s_nxt.skip = link_s.read_data;
      end
    end

    // condition test of the result
    if (s_r.cond == header_compare_pkg::COND_TEST_COMPARE) begin
      s_nxt.mismatch_n = ~s_r.compare;
    end else begin
      s_nxt.mismatch_n = 1'b1;
    end
    s_nxt.sync_pattern = s_r.drive_type ? header_compare_pkg::SYNC_PATTERN_20 :
                         header_compare_pkg::SYNC_PATTERN_16;

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    mapped = (paddr == header_compare_pkg::OFS_CONTROL) ||
             (paddr == header_compare_pkg::OFS_ADDRESS) ||
             (paddr == header_compare_pkg::OFS_STATUS) ||
             (paddr == header_compare_pkg::OFS_SYNC_PATTERN);
    read_word = '0;
    case (paddr)
      header_compare_pkg::OFS_CONTROL: begin
        read_word[header_compare_pkg::CTL_DRIVE_TYPE] = s_r.drive_type;
        read_word[header_compare_pkg::CTL_WRITE_CHECK] = s_r.write_check;
        read_word[header_compare_pkg::CTL_CLEAR_ENABLE] = s_r.clear_enable;
        read_word[header_compare_pkg::CTL_SKIP_INHIBIT_N] = s_r.skip_inhibit_n;
        read_word[header_compare_pkg::CTL_COND_MSB:header_compare_pkg::CTL_COND_LSB] = s_r.cond;
      end
      header_compare_pkg::OFS_ADDRESS: begin
        read_word[header_compare_pkg::ADDR_BITS-1:0] = s_r.address;
      end
      header_compare_pkg::OFS_STATUS: begin
        read_word[header_compare_pkg::STS_COMPARE] = s_r.compare;
        read_word[header_compare_pkg::STS_MISMATCH_N] = s_r.mismatch_n;
        read_word[header_compare_pkg::STS_SKIP] = s_r.skip;
        read_word[header_compare_pkg::STS_SYNC] = link_s.sync_found;
        read_word[header_compare_pkg::STS_COUNT_MSB:header_compare_pkg::STS_COUNT_LSB] =
          s_r.count;
      end
      header_compare_pkg::OFS_SYNC_PATTERN: begin
        read_word[7:0] = s_r.sync_pattern;
      end
      default: begin
        read_word = '0;
      end
    endcase

    access = psel & penable & ~s_r.pready;
    s_nxt.pready = access;
    s_nxt.pslverr = access & ~mapped;
    if (access) begin
      s_nxt.prdata = pwrite ? 32'h00000000 : read_word;
    end
    if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
      if (paddr == header_compare_pkg::OFS_CONTROL) begin
        s_nxt.drive_type = pwdata[header_compare_pkg::CTL_DRIVE_TYPE];
        s_nxt.write_check = pwdata[header_compare_pkg::CTL_WRITE_CHECK];
        s_nxt.clear_enable = pwdata[header_compare_pkg::CTL_CLEAR_ENABLE];
        s_nxt.skip_inhibit_n = pwdata[header_compare_pkg::CTL_SKIP_INHIBIT_N];
        s_nxt.cond = pwdata[header_compare_pkg::CTL_COND_MSB:header_compare_pkg::CTL_COND_LSB];
      end
      if (paddr == header_compare_pkg::OFS_ADDRESS) begin
        s_nxt.address = pwdata[header_compare_pkg::ADDR_BITS-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= header_compare_pkg::STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign serial_address_bit = s_r.serial_bit;
  assign mismatch_n = s_r.mismatch_n;
  assign skip_sector_detect = s_r.skip;
  assign drive_type_select = s_r.drive_type;
  assign sync_pattern_constant = s_r.sync_pattern;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_held_set;
    !link_s.sync_found |=> s_r.compare;
  endproperty
  a_held_set: assert property (p_held_set) else $error("compare not held set");

  property p_clear_zero;
    !link_s.sync_found && s_r.clear_enable |=> s_r.count == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("count not cleared");

  property p_preset;
    link_s.sync_found && !s_r.sync_prev |=>
      s_r.count == header_compare_pkg::FIRST_COUNT && !s_r.compare;
  endproperty
  a_preset: assert property (p_preset) else $error("count not preset to one");

  property p_sticky;
    link_s.sync_found && s_r.sync_prev && s_r.compare |=> s_r.compare;
  endproperty
  a_sticky: assert property (p_sticky) else $error("compare lost its set state");

  property p_step;
    step |=> s_r.count == $past(s_r.count) + header_compare_pkg::FIRST_COUNT
      && s_r.compare == ($past(s_r.compare) | ($past(s_r.serial_bit) ^ $past(masked_data)));
  endproperty
  a_step: assert property (p_step) else $error("bit step wrong");

  property p_first_short;
    !link_s.sync_found && s_r.count == '0 && !s_r.drive_type |=>
      s_r.serial_bit == $past(s_r.address[0]);
  endproperty
  a_first_short: assert property (p_first_short) else $error("first bit not 0");

  property p_first_long;
    !link_s.sync_found && s_r.count == '0 && s_r.drive_type |=>
      s_r.serial_bit == $past(s_r.address[9]);
  endproperty
  a_first_long: assert property (p_first_long) else $error("first bit not 9");

  property p_result;
    s_r.cond == header_compare_pkg::COND_TEST_COMPARE |=> mismatch_n == !$past(s_r.compare);
  endproperty
  a_result: assert property (p_result) else $error("mismatch output wrong");

  property p_idle;
    s_r.cond != header_compare_pkg::COND_TEST_COMPARE |=> mismatch_n;
  endproperty
  a_idle: assert property (p_idle) else $error("mismatch low while untested");

  property p_force;
    s_r.serial_force |-> s_r.serial_bit && s_r.drive_type;
  endproperty
  a_force: assert property (p_force) else $error("masked slot not high");

  property p_pattern;
    s_r.drive_type ##1 s_r.drive_type |->
      sync_pattern_constant == header_compare_pkg::SYNC_PATTERN_20;
  endproperty
  a_pattern: assert property (p_pattern) else $error("long sync pattern wrong");

  property p_pattern_short;
    !s_r.drive_type ##1 !s_r.drive_type |->
      sync_pattern_constant == header_compare_pkg::SYNC_PATTERN_16;
  endproperty
  a_pattern_short: assert property (p_pattern_short) else $error("short pattern");

  property p_pass_short;
    !s_r.drive_type |-> masked_data == link_s.read_data;
  endproperty
  a_pass_short: assert property (p_pass_short) else $error("short data masked");

  property p_mask_long;
    s_r.drive_type && !s_r.write_check && s_r.serial_force |-> masked_data;
  endproperty
  a_mask_long: assert property (p_mask_long) else $error("flag data not high");

  property p_skip_latch;
    step && s_r.drive_type && s_r.skip_inhibit_n &&
      s_r.count == header_compare_pkg::SKIP_COUNT |=> s_r.skip == $past(link_s.read_data);
  endproperty
  a_skip_latch: assert property (p_skip_latch) else $error("skip not latched");

  property p_skip_inhibit;
    step && !s_r.skip_inhibit_n |=> $stable(s_r.skip);
  endproperty
  a_skip_inhibit: assert property (p_skip_inhibit) else $error("skip moved");

  property p_no_check;
    link_s.sync_found && s_r.sync_prev && s_r.write_check |=>
      $stable(s_r.compare) && $stable(s_r.count);
  endproperty
  a_no_check: assert property (p_no_check) else $error("compared in check");

  property p_hold_done;
    link_s.sync_found && s_r.sync_prev && s_r.count > hdr_len |=>
      $stable(s_r.compare) && $stable(s_r.count);
  endproperty
  a_hold_done: assert property (p_hold_done) else $error("result moved");

  property p_short_order;
    step && !s_r.drive_type |=>
      s_r.serial_bit == $past(s_r.address[s_r.count[header_compare_pkg::INDEX_BITS-1:0]]);
  endproperty
  a_short_order: assert property (p_short_order) else $error("short order wrong");

  property p_hold_first;
    link_s.sync_found && !s_r.sync_prev |=> $stable(s_r.serial_bit);
  endproperty
  a_hold_first: assert property (p_hold_first) else $error("first bit lost");

  property p_long_flags;
    step && s_r.drive_type && s_r.count > header_compare_pkg::SEG_HIGH_END &&
      s_r.count < header_compare_pkg::SEG_LOW_START |=> s_r.serial_bit && s_r.serial_force;
  endproperty
  a_long_flags: assert property (p_long_flags) else $error("flag bit not high");

  property p_long_low;
    step && s_r.drive_type && s_r.count == header_compare_pkg::SEG_LOW_START |=>
      s_r.serial_bit == $past(s_r.address[0]);
  endproperty
  a_long_low: assert property (p_long_low) else $error("low segment wrong");

  c_sync: cover property (link_s.sync_found && !s_r.sync_prev);
  c_mismatch: cover property (s_r.cond == header_compare_pkg::COND_TEST_COMPARE ##1 !mismatch_n);
  c_done16: cover property (!s_r.drive_type && s_r.count == LEN16 + header_compare_pkg::FIRST_COUNT
    && !s_r.compare);
  c_skip: cover property (s_r.skip);
  c_inhibit: cover property (step && !s_r.skip_inhibit_n &&
    s_r.count == header_compare_pkg::SKIP_COUNT);

endmodule

// File: tb/link_stream_model.sv
module link_stream_model (
  output header_compare_pkg::link_type link,
  input wire logic serial_bit
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // serial header stream from the drive
  // ---------------------------------------------------------------
  logic [31:0] seen;

  initial begin
    link = '0;
    seen = '0;
  end

  // sync found, then a settling gap before the first bit clock
  task automatic sync_on();
    #0.2;
    link.sync_found = 1'b1;
    #40;
  endtask

  task automatic sync_off();
    #0.2;
    link.sync_found = 1'b0;
  endtask

  // data changes in the low half, stable around each rising edge
  // serial bit is sampled just before the edge that compares it
  task automatic send(input logic [31:0] bits, input int n);
    #0.2;
    for (int k = 0; k < n; k++) begin
      link.read_data = bits[k];
      #62.5;
      seen[k] = serial_bit;
      link.link_clk = 1'b1;
      #62.5;
      link.link_clk = 1'b0;
    end
    // clock stands still; released data line shows the inverse
    link.read_data = ~bits[n-1];
  endtask
endmodule

// File: tb/header_comparator_tb.sv
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module header_comparator_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [header_compare_pkg::PADDR_BITS-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  header_compare_pkg::link_type link;
  logic serial_address_bit;
  logic mismatch_n;
  logic skip_sector_detect;
  logic drive_type_select;
  logic [7:0] sync_pattern_constant;
  logic [31:0] rdata;
  logic rerr;
  logic [1:0] ctl_mid;
  int miscompares;
  int tests_run;

  header_comparator i_header_comparator (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_in(link), .serial_address_bit(serial_address_bit), .mismatch_n(mismatch_n),
    .skip_sector_detect(skip_sector_detect), .drive_type_select(drive_type_select),
    .sync_pattern_constant(sync_pattern_constant)
  );

  link_stream_model i_link_stream_model (
    .link(link),
    .serial_bit(serial_address_bit)
  );

  always #2 pclk = ~pclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      conclude();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input logic dt, input logic wc, input logic [1:0] c);
    return {26'h0, c, ctl_mid, wc, dt};
  endfunction

  // long header layout; fill supplies the masked positions
  function automatic logic [31:0] lh(input logic [19:0] a, input logic [31:0] fill);
    logic [31:0] h;
    h = fill;
    for (int p = 0; p <= 10; p++) h[p] = a[p+9];
    for (int p = 16; p <= 24; p++) h[p] = a[p-16];
    return h;
  endfunction

  // one header frame: set up, sync, stream, test the result
  task automatic run(input logic dt, input logic wc, input logic [19:0] a,
      input logic [31:0] hdr, input logic [31:0] ser, input int n, input logic mm,
      input logic sk);
    logic [31:0] mask;
    mask = (n == 32) ? 32'hffffffff : 32'h0000ffff;
    apb(1'b1, header_compare_pkg::OFS_ADDRESS, {12'h000, a});
    apb(1'b1, header_compare_pkg::OFS_CONTROL, ctl(dt, wc, 2'b00));
    repeat (2) @(posedge pclk);
    `CHK(drive_type_select, dt)
    `CHK(serial_address_bit, ser[0])
    apb(1'b0, header_compare_pkg::OFS_STATUS, 32'h0);
    `CHK(rdata[13:0], 14'h0003)
    i_link_stream_model.sync_on();
    apb(1'b0, header_compare_pkg::OFS_STATUS, 32'h0);
    `CHK(rdata[13:0], 14'h010a)
    i_link_stream_model.send(hdr, n);
    `CHK(i_link_stream_model.seen & mask, (wc ? {32{ser[0]}} : ser) & mask)
    repeat (8) @(posedge pclk);
    `CHK(skip_sector_detect, sk)
    apb(1'b0, header_compare_pkg::OFS_STATUS, 32'h0);
    `CHK(rdata[13:8], wc ? 6'h01 : 6'(n + 1))
    `CHK(mismatch_n, 1'b1)
    apb(1'b1, header_compare_pkg::OFS_CONTROL, ctl(dt, wc, 2'b10));
    repeat (2) @(posedge pclk);
    `CHK(mismatch_n, mm)
    apb(1'b1, header_compare_pkg::OFS_CONTROL, ctl(dt, wc, 2'b01));
    repeat (2) @(posedge pclk);
    `CHK(mismatch_n, 1'b1)
    i_link_stream_model.sync_off();
    repeat (8) @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    `CHK(sync_pattern_constant, 8'h80)
    apb(1'b0, header_compare_pkg::OFS_CONTROL, 32'h0);
    `CHK(rdata, 32'h00000008)
    apb(1'b1, header_compare_pkg::OFS_ADDRESS, 32'hffffffff);
    apb(1'b0, header_compare_pkg::OFS_ADDRESS, 32'h0);
    `CHK(rdata, 32'h000fffff)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({rerr, rdata}, 33'h100000000)
    apb(1'b1, header_compare_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 2'b00));
    repeat (3) @(posedge pclk);
    `CHK(sync_pattern_constant, 8'h19)
    `CHK(drive_type_select, 1'b1)
    apb(1'b0, header_compare_pkg::OFS_SYNC_PATTERN, 32'h0);
    `CHK(rdata, 32'h00000019)
    $display("test regs done");
  endtask

  task automatic t_short();
    run(1'b0, 1'b0, 20'h5a5c3, 32'h0000a5c3, 32'h0000a5c3, 16, 1'b1, 1'b0);
    run(1'b0, 1'b0, 20'h5a5c3, 32'h000025c3, 32'h0000a5c3, 16, 1'b0, 1'b0);
    $display("test short header done");
  endtask

  task automatic t_long();
    run(1'b1, 1'b0, 20'h9c36b, lh(20'h9c36b, 32'h5a5aa5a5), lh(20'h9c36b, 32'hffffffff),
      32, 1'b1, 1'b1);
    run(1'b1, 1'b0, 20'h9c36b, lh(20'h9c36b, 32'h0) ^ 32'h00010000,
      lh(20'h9c36b, 32'hffffffff), 32, 1'b0, 1'b0);
    ctl_mid = 2'b01;
    run(1'b1, 1'b0, 20'h9c36b, lh(20'h9c36b, 32'h5a5aa5a5), lh(20'h9c36b, 32'hffffffff),
      32, 1'b1, 1'b0);
    ctl_mid = 2'b11;
    $display("test long header done");
  endtask

  task automatic t_wcheck();
    run(1'b0, 1'b1, 20'h0f0f0, 32'h0000f0f0 ^ 32'h0000ffff, 32'h0000f0f0, 16, 1'b1, 1'b0);
    ctl_mid = 2'b10;
    apb(1'b1, header_compare_pkg::OFS_CONTROL, ctl(1'b0, 1'b1, 2'b00));
    i_link_stream_model.sync_on();
    i_link_stream_model.sync_off();
    repeat (8) @(posedge pclk);
    apb(1'b0, header_compare_pkg::OFS_STATUS, 32'h0);
    `CHK(rdata[13:0], 14'h0103)
    ctl_mid = 2'b11;
    apb(1'b1, header_compare_pkg::OFS_CONTROL, ctl(1'b0, 1'b1, 2'b00));
    repeat (2) @(posedge pclk);
    apb(1'b0, header_compare_pkg::OFS_STATUS, 32'h0);
    `CHK(rdata[13:0], 14'h0003)
    $display("test write check done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    miscompares = 0;
    tests_run = 0;
    ctl_mid = 2'b11;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_short();
    t_long();
    t_wcheck();
    conclude();
  end
endmodule
